// ===== verification/lic_line_model.sv
// Line side model: one receive symbol per bit period
module lic_line_model
    import lic_pkg::*;
#(
    parameter int unsigned BIT_DIV = 6
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic [1:0]          mode_i,
    output lic_pkg::lic_rails_t      rails_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned div;
    logic [2:0]  slot;
    logic        pol;
    lic_rails_t  sym;
    // Mode 1 alternating marks, mode 2 a repeated zero substitution word
    always_comb begin
        sym = 2'h0;
        if (mode_i == 2'h1) begin
            sym = pol ? 2'h2 : 2'h1;
        end else if (mode_i == 2'h2) begin
            if (slot == 3'h3 || slot == 3'h7) begin
                sym = 2'h2;
            end else if (slot == 3'h4 || slot == 3'h6) begin
                sym = 2'h1;
            end
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            div <= 0;
            slot <= 3'h0;
            pol <= 1'h0;
            rails_o <= 2'h0;
        end else if (div == BIT_DIV - 1) begin
            div <= 0;
            slot <= slot + 3'h1;
            pol <= ~pol;
            rails_o <= sym;
        end else begin
            div <= div + 1;
        end
    end
endmodule

// ===== verification/lic_top_sva.sv
// Port checker for the line interface control block
`include "lic_defs.svh"
module lic_top_sva
    import lic_pkg::*;
#(
    parameter int unsigned BIT_DIV = `LIC_BIT_DIV
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [15:0]         wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [31:0]         wb_dat_o,
    input  wire logic                wb_ack_o,
    input  wire logic                tx_pcm_ready_o,
    input  wire logic                rx_pcm_valid_o,
    input  wire lic_pkg::lic_rails_t transmit_line_pair_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import lic_pkg::*;
    // Eight bit periods through the window, plus margin
    localparam int unsigned LAT = 10 * BIT_DIV + 2;
    logic [7:0] shadow;
    logic [7:0] age;
    logic [7:0] gap;
    logic       wr;
    logic       rd;
    assign wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i[15:2] == `LIC_CTRL_IDX;
    assign rd = wb_ack_o && !wb_we_i;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shadow <= `LIC_CTRL_RESET;
        end else if (wr) begin
            shadow <= wb_dat_i[7:0];
        end
    end
    // Saturating, so old settings never wrap back into a young age
    always_ff @(posedge clk_i) begin
        if (rst_i || wr) begin
            age <= 8'h00;
        end else if (age != 8'hff) begin
            age <= age + 8'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || rx_pcm_valid_o) begin
            gap <= {7'h00, !rst_i};
        end else if (gap != 8'hff) begin
            gap <= gap + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ctrl_readback: assert property (
        rd && wb_adr_i[15:2] == `LIC_CTRL_IDX
        |-> wb_dat_o == {24'h000000, shadow})
        else $error("control read back differs");
    a_hole_zero: assert property (rd && wb_adr_i[15:2] != `LIC_CTRL_IDX
        && wb_adr_i[15:2] != `LIC_STAT_IDX |-> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_loss_quiet: assert property (
        shadow[7] && age >= LAT |-> transmit_line_pair_o == 2'h0)
        else $error("pulses sent while loss pattern forced");
    a_single_rail: assert property (
        shadow[6] && age >= LAT |-> !transmit_line_pair_o.neg)
        else $error("negative rail used in single rail");
    a_local_marks: assert property (
        shadow[7:4] == 4'h1 && age >= LAT
        |-> transmit_line_pair_o.pos ^ transmit_line_pair_o.neg)
        else $error("local loop line not all marks");
    a_remote_no_rx: assert property (
        shadow[5:4] == 2'h2 && age >= 2 |-> !rx_pcm_valid_o)
        else $error("receive output during remote loop");
    a_payload_stall: assert property (
        shadow[5:4] == 2'h3 && age >= 2 |-> !tx_pcm_ready_o)
        else $error("transmit input open during payload loop");
    a_rx_cadence: assert property (
        rx_pcm_valid_o && shadow[5] == shadow[4] && age >= 3 * BIT_DIV
        |-> gap == BIT_DIV)
        else $error("receive bits not one per bit period");
endmodule

bind lic_top lic_top_sva #(.BIT_DIV(BIT_DIV)) lic_top_sva_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tx_pcm_ready_o(tx_pcm_ready_o),
    .rx_pcm_valid_o(rx_pcm_valid_o),
    .transmit_line_pair_o(transmit_line_pair_o));

// ===== verification/lic_top_tb.sv
// Self-checking bench for the line interface control block
`include "lic_defs.svh"
module lic_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lic_pkg::*;
    // Short bit period keeps the run brief
    localparam int unsigned DIV = 4;
    localparam logic [15:0] CTRL = {`LIC_CTRL_IDX, 2'h0};
    localparam logic [15:0] STAT = {`LIC_STAT_IDX, 2'h0};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        tx_pcm_valid_i = 1'b0;
    logic [0:0]  tx_pcm_data_i = 1'h0;
    logic        tx_pcm_ready_o;
    logic        rx_pcm_valid_o;
    logic [0:0]  rx_pcm_data_o;
    lic_rails_t  line_in;
    lic_rails_t  line_out;
    logic [1:0]  line_mode = 2'h0;
    logic [31:0] rd;
    logic        ok;
    logic        exp_q[$];
    int unsigned mismatches = 0;
    int unsigned num_checks = 0;
    always #50 clk_i = ~clk_i;
    lic_top #(.BIT_DIV(DIV)) lic_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .tx_pcm_valid_i(tx_pcm_valid_i),
        .tx_pcm_data_i(tx_pcm_data_i), .tx_pcm_ready_o(tx_pcm_ready_o),
        .rx_pcm_valid_o(rx_pcm_valid_o), .rx_pcm_data_o(rx_pcm_data_o),
        .receive_line_pair_i(line_in), .transmit_line_pair_o(line_out));
    lic_line_model #(.BIT_DIV(DIV)) lic_line_model_i (.clk_i(clk_i),
        .rst_i(rst_i), .mode_i(line_mode), .rails_o(line_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [15:0] a,
                      input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h000000, d};
        // No limit here: only the watchdog ends a hung bus cycle
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // Registered slave: ack is seen at the second edge
        check(n, 2);
    endtask
    // Write the control byte, then let both eight-bit windows refill;
    // remote loop chains the receive and transmit windows
    task automatic setc(input logic [7:0] v);
        wb(1'b1, CTRL, v, 4'h1);
        repeat (24 * DIV) @(posedge clk_i);
    endtask
    task automatic marks(input int unsigned n, input logic [31:0] exp);
        logic [31:0] cnt;
        cnt = 0;
        repeat (n) begin
            repeat (DIV) @(posedge clk_i);
            cnt += {31'h0, line_out.pos | line_out.neg};
        end
        check(cnt, exp);
    endtask
    task automatic rx_ones(input int unsigned n, input logic [31:0] exp);
        logic [31:0] got;
        logic [31:0] ones;
        int unsigned t;
        got = 0;
        ones = 0;
        t = 0;
        while (got < n && t < 3 * n * DIV) begin
            @(posedge clk_i);
            t++;
            if (rx_pcm_valid_o === 1'b1) begin
                got++;
                ones += {31'h0, rx_pcm_data_o};
            end
        end
        check(got, n);
        check(ones, exp);
    endtask
    task automatic send(input logic b);
        int n;
        n = 0;
        @(posedge clk_i);
        tx_pcm_valid_i <= 1'b1;
        tx_pcm_data_i <= b;
        do begin
            @(posedge clk_i);
            n++;
        end while (tx_pcm_ready_o !== 1'b1 && n < 20);
        ok = (tx_pcm_ready_o === 1'b1);
        tx_pcm_valid_i <= 1'b0;
        if (ok) exp_q.push_back(b);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (rx_pcm_valid_o === 1'b1 && exp_q.size() > 0) begin
            check({31'h0, rx_pcm_data_o}, {31'h0, exp_q.pop_front()});
        end
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        wrap_up();
    end
    initial begin
        logic [7:0] v;
        v = 8'($urandom(12357));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, CTRL, 8'h00, 4'h1);
        check(rd, 32'h0);
        v = 8'($urandom);
        wb(1'b1, CTRL, v, 4'h1);
        wb(1'b1, CTRL, ~v, 4'h0);
        wb(1'b0, CTRL, 8'h00, 4'h1);
        check(rd, {24'h0, v});
        wb(1'b1, 16'h0500, 8'h5a, 4'h1);
        wb(1'b0, 16'h0500, 8'h00, 4'h1);
        check(rd, 32'h0);
        line_mode <= 2'h1;
        setc(8'h00);
        rx_ones(16, 16);
        line_mode <= 2'h2;
        setc(8'h00);
        rx_ones(16, 0);
        setc(8'h01);
        rx_ones(16, 8);
        line_mode <= 2'h0;
        setc(8'h02);
        marks(16, 0);
        setc(8'h00);
        marks(16, 8);
        line_mode <= 2'h1;
        setc(8'h10);
        marks(16, 16);
        for (int i = 0; i < 12; i++) send(1'($urandom));
        repeat (8 * DIV) @(posedge clk_i);
        check(exp_q.size(), 0);
        setc(8'h50);
        marks(16, 16);
        setc(8'h90);
        marks(16, 0);
        setc(8'h20);
        marks(16, 16);
        repeat (3) send(1'b1);
        check({31'h0, ok}, 32'h0);
        exp_q.delete();
        wb(1'b0, STAT, 8'h00, 4'h1);
        check({30'h0, rd[1:0]}, 32'h2);
        setc(8'h30);
        marks(16, 16);
        rx_ones(8, 8);
        wrap_up();
    end
endmodule

// ===== verilog/lic_defs.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef LIC_DEFS_SVH
`define LIC_DEFS_SVH

// Register indices; byte address is four times the index
`define LIC_CTRL_IDX      14'h0101
`define LIC_STAT_IDX      14'h0102

`define LIC_CTRL_RESET    8'h00
`define LIC_STAT_ZERO     4'h0

// Control field positions
`define LIC_FORCE_SIGNAL_LOSS_PATTERN_BIT 7
`define LIC_SR_BIT        6
`define LIC_LOOP_HI       5
`define LIC_LOOP_LO       4
`define LIC_ENC_DIS_BIT   1
`define LIC_DEC_DIS_BIT   0

// Loopback codes
`define LIC_LOOP_NONE     2'h0
`define LIC_LOOP_LOCAL    2'h1
`define LIC_LOOP_REMOTE   2'h2
`define LIC_LOOP_PAYLOAD  2'h3

// Transmit symbol codes and the eight-zero substitution, oldest first
`define LIC_SYM_ZERO      2'h0
`define LIC_SYM_MARK      2'h1
`define LIC_SYM_VIOL      2'h2
`define LIC_SUB_PATTERN   16'h0249
`define LIC_WIN_ZERO      16'h0000

// Clock cycles per line bit
`define LIC_BIT_DIV       6
`define LIC_BUF_DEPTH     2
`define LIC_BUF_WIDTH     1

`endif

// ===== verilog/lic_pkg.sv
// Types shared by the line interface control block
package lic_pkg;

    typedef struct packed {
        logic pos;
        logic neg;
    } lic_rails_t;

    typedef lic_rails_t [7:0] lic_win_t;

    typedef struct packed {
        logic       force_signal_loss_pattern;
        logic       single_rail_select;
        logic [1:0] framer_loopback_select;
        logic [1:0] spare;
        logic       tx_zero_sub_encoder_disable;
        logic       rx_zero_sub_decoder_disable;
    } lic_ctrl_t;

endpackage

// ===== verilog/lic_top.sv
// Line interface control: register, loopbacks, zero-substitution line code
//
// Behaviour
// - Control bit 7 set sends the loss-of-signal pattern; clear sends traffic.
// - Bit 6: 0 dual rail, 1 single rail; only with interface unit single rail.
// - Loopback 01 returns transmit PCM input onto the receive PCM output.
// - Loopback 01 ignores the receive line pair and transmits all ones.
// - Loopback 10 returns decoded line data to the line, bypassing framing.
// - Loopback 11 sends received time slots to transmit framer, transmit timing.
// - Bit 1: 0 enables transmit zero substitution, 1 disables it.
// - Transmit encoder disabled means plain AMI on the line.
// - Bit 0: 0 enables receive zero-substitution decoding, 1 disables it.
// - Receive decoder disabled means incoming signal is read as plain AMI.
`include "lic_defs.svh"

module lic_top #(
    parameter int unsigned BIT_DIV   = `LIC_BIT_DIV,
    parameter int unsigned BUF_DEPTH = `LIC_BUF_DEPTH,
    parameter int unsigned BUF_WIDTH = `LIC_BUF_WIDTH
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [15:0]        wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               tx_pcm_valid_i,
    input  wire logic [BUF_WIDTH-1:0] tx_pcm_data_i,
    output logic                    tx_pcm_ready_o,
    output logic                    rx_pcm_valid_o,
    output logic [BUF_WIDTH-1:0]    rx_pcm_data_o,
    input  wire lic_pkg::lic_rails_t receive_line_pair_i,
    output lic_pkg::lic_rails_t     transmit_line_pair_o
);
    import lic_pkg::*;

    localparam int unsigned PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int unsigned CW = $clog2(BUF_DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic lic_mark(input lic_rails_t r);
        lic_mark = r.pos | r.neg;
    endfunction

    // Window oldest in slot 7: 0 0 0 V B 0 V B
    function automatic logic lic_sub_hit(input lic_win_t w,
                                         input logic     prev_pol);
        logic shape;
        logic pols;
        shape = ~lic_mark(w[7]) & ~lic_mark(w[6]) & ~lic_mark(w[5]) &
                lic_mark(w[4]) & lic_mark(w[3]) & ~lic_mark(w[2]) &
                lic_mark(w[1]) & lic_mark(w[0]);
        pols  = (w[4].pos == prev_pol) & (w[3].pos != w[4].pos) &
                (w[1].pos == w[3].pos) & (w[0].pos != w[1].pos);
        lic_sub_hit = shape & pols;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    lic_ctrl_t              ctrl;
    lic_ctrl_t              next_ctrl;
    logic [7:0]             div_cnt;
    logic                   bit_en;
    lic_rails_t             rx_s1;
    lic_rails_t             rx_s2;
    lic_rails_t             rx_s3;
    lic_rails_t             rx_line;
    lic_win_t               rx_win;
    lic_win_t               next_rx_win;
    lic_rails_t             rx_in;
    lic_rails_t             rx_leave;
    logic                   rx_last_pol;
    logic                   rx_prev_pol;
    logic                   rx_hit;
    logic                   rx_bit;
    logic [15:0]            tx_win;
    logic [15:0]            next_tx_win;
    logic [1:0]             tx_leave;
    logic                   tx_last_pol;
    logic                   tx_pol;
    logic                   tx_bit;
    logic [BUF_WIDTH-1:0]   buf_mem [BUF_DEPTH];
    logic [PW-1:0]          wr_ptr;
    logic [PW-1:0]          rd_ptr;
    logic [CW-1:0]          buf_cnt;
    logic [CW-1:0]          next_buf_cnt;
    logic                   push;
    logic                   push_ok;
    logic [BUF_WIDTH-1:0]   push_data;
    logic                   pop;
    logic [BUF_WIDTH-1:0]   pop_data;
    logic                   req;
    logic                   hit_ctrl;
    logic                   hit_stat;
    logic [7:0]             status;
    logic [1:0]             loop;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave, one wait state: ack the cycle after the request

    assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign hit_ctrl = wb_adr_i[15:2] == `LIC_CTRL_IDX;
    assign hit_stat = wb_adr_i[15:2] == `LIC_STAT_IDX;
    assign status   = {`LIC_STAT_ZERO, rx_last_pol, tx_last_pol,
                       2'(buf_cnt)};

    always_comb begin
        next_ctrl = ctrl;
        if (req && wb_we_i && hit_ctrl && wb_sel_i[0]) begin
            next_ctrl = lic_ctrl_t'(wb_dat_i[7:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= lic_ctrl_t'(`LIC_CTRL_RESET);
        end else begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i && hit_ctrl) begin
                wb_dat_o <= {24'h00_0000, ctrl};
            end else if (req && !wb_we_i && hit_stat) begin
                wb_dat_o <= {24'h00_0000, status};
            end else begin
                // Unmapped reads answer zero, writes are dropped
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    assign loop = ctrl.framer_loopback_select;

    ////////////////////////////////////////////////////////////////////////
    // Line bit rate enable

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= 8'h00;
            bit_en  <= 1'b0;
        end else if (div_cnt == 8'(BIT_DIV - 1)) begin
            div_cnt <= 8'h00;
            bit_en  <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
            bit_en  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive pins: three stages, a change counts when stages two and three
    // agree, which rejects a single sampled glitch

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1   <= '0;
            rx_s2   <= '0;
            rx_s3   <= '0;
            rx_line <= '0;
        end else begin
            rx_s1 <= receive_line_pair_i;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3) begin
                rx_line <= rx_s2;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive decoder: eight-bit window, so data lags the line by 8 bits

    always_comb begin
        rx_in = rx_line;
        if (loop == `LIC_LOOP_LOCAL) begin
            rx_in = '0;
        end else if (ctrl.single_rail_select) begin
            rx_in = '{pos: rx_line.pos, neg: 1'b0};
        end
    end

    assign rx_leave    = rx_win[7];
    assign rx_bit      = lic_mark(rx_leave);
    assign rx_prev_pol = rx_bit ? rx_leave.pos : rx_last_pol;
    assign rx_hit      = ~ctrl.single_rail_select &
                         ~ctrl.rx_zero_sub_decoder_disable &
                         lic_sub_hit(next_rx_win, rx_prev_pol);

    always_comb begin
        next_rx_win = {rx_win[6:0], rx_in};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_win      <= '0;
            rx_last_pol <= 1'b0;
        end else if (bit_en) begin
            if (rx_hit) begin
                // Substituted zeros; polarity carries on from the last B
                rx_win      <= '0;
                rx_last_pol <= next_rx_win[0].pos;
            end else begin
                rx_win <= next_rx_win;
                if (rx_bit) begin
                    rx_last_pol <= rx_leave.pos;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-entry transmit buffer; in payload loopback the received bits fill
    // it, and a full buffer pops on that same bit, so none are dropped

    always_comb begin
        if (loop == `LIC_LOOP_PAYLOAD) begin
            push      = bit_en;
            push_data = BUF_WIDTH'(rx_bit);
        end else begin
            push      = tx_pcm_valid_i & tx_pcm_ready_o;
            push_data = tx_pcm_data_i;
        end
    end

    assign pop      = bit_en & (buf_cnt != '0) &
                      (loop != `LIC_LOOP_REMOTE);
    assign pop_data = buf_mem[rd_ptr];
    assign push_ok  = push & ((buf_cnt != CW'(BUF_DEPTH)) | pop);

    always_comb begin
        next_buf_cnt = buf_cnt;
        if (push_ok && !pop) begin
            next_buf_cnt = buf_cnt + CW'(1);
        end else if (pop && !push_ok) begin
            next_buf_cnt = buf_cnt - CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (push_ok) begin
            buf_mem[wr_ptr] <= push_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr         <= '0;
            rd_ptr         <= '0;
            buf_cnt        <= '0;
            tx_pcm_ready_o <= 1'b0;
        end else begin
            if (push_ok) begin
                wr_ptr <= (wr_ptr == PW'(BUF_DEPTH - 1)) ? '0 :
                          wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(BUF_DEPTH - 1)) ? '0 :
                          rd_ptr + PW'(1);
            end
            buf_cnt        <= next_buf_cnt;
            // Backplane stalls while full or while payload loop owns the fill
            tx_pcm_ready_o <= (next_buf_cnt != CW'(BUF_DEPTH)) &&
                (next_ctrl.framer_loopback_select != `LIC_LOOP_PAYLOAD);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive PCM output

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_pcm_valid_o <= 1'b0;
            rx_pcm_data_o  <= '0;
        end else begin
            rx_pcm_valid_o <= 1'b0;
            if (loop == `LIC_LOOP_LOCAL) begin
                if (pop) begin
                    rx_pcm_valid_o <= 1'b1;
                    rx_pcm_data_o  <= pop_data;
                end
            end else if (loop != `LIC_LOOP_REMOTE && bit_en) begin
                rx_pcm_valid_o <= 1'b1;
                rx_pcm_data_o  <= BUF_WIDTH'(rx_bit);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit encoder: same eight-bit window, violations carry the polarity
    // of the previous mark

    always_comb begin
        case (loop)
            `LIC_LOOP_LOCAL:  tx_bit = 1'b1;
            `LIC_LOOP_REMOTE: tx_bit = rx_bit;
            default:          tx_bit = pop & pop_data[0];
        endcase
    end

    always_comb begin
        next_tx_win = {tx_win[13:0],
                       tx_bit ? `LIC_SYM_MARK : `LIC_SYM_ZERO};
        if (!ctrl.single_rail_select &&
            !ctrl.tx_zero_sub_encoder_disable &&
            next_tx_win == `LIC_WIN_ZERO) begin
            next_tx_win = `LIC_SUB_PATTERN;
        end
    end

    assign tx_leave = tx_win[15:14];
    assign tx_pol   = (tx_leave == `LIC_SYM_VIOL) ? tx_last_pol :
                      ~tx_last_pol;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_win               <= `LIC_WIN_ZERO;
            tx_last_pol          <= 1'b0;
            transmit_line_pair_o <= '0;
        end else if (bit_en) begin
            tx_win <= next_tx_win;
            if (tx_leave != `LIC_SYM_ZERO) begin
                tx_last_pol <= tx_pol;
            end
            if (ctrl.force_signal_loss_pattern) begin
                transmit_line_pair_o <= '0;
            end else if (ctrl.single_rail_select) begin
                transmit_line_pair_o <= '{pos: tx_leave != `LIC_SYM_ZERO,
                                           neg: 1'b0};
            end else if (tx_leave == `LIC_SYM_ZERO) begin
                transmit_line_pair_o <= '0;
            end else begin
                transmit_line_pair_o <= '{pos: tx_pol, neg: ~tx_pol};
            end
        end
    end

endmodule
